// ==== design/alc_pkg.sv ====
// shared constants and types for the frequency/gain loop configuration block
package alc_pkg;

  // register offsets on the serial control port
  localparam logic [7:0] ALC_ADDR_GAIN1_HI = 8'h2e;
  localparam logic [7:0] ALC_ADDR_GAIN2_LO = 8'h2f;
  localparam logic [7:0] ALC_ADDR_GAIN2_HI = 8'h30;
  localparam logic [7:0] ALC_ADDR_PEAK = 8'h31;
  localparam logic [7:0] ALC_ADDR_START_FREEZE = 8'h32;

  // reset values
  localparam logic [7:0] ALC_RST_GAIN1_HI = 8'h00;
  localparam logic [7:0] ALC_RST_GAIN2_LO = 8'h00;
  localparam logic [7:0] ALC_RST_GAIN2_HI = 8'h00;
  localparam logic [7:0] ALC_RST_PEAK = 8'h42;
  localparam logic [7:0] ALC_RST_START_FREEZE = 8'h00;

  // field positions
  localparam int ALC_NIB_MSB = 3;
  localparam int ALC_PK_UP_MSB = 6;
  localparam int ALC_PK_UP_LSB = 4;
  localparam int ALC_PK_DN_MSB = 2;
  localparam int ALC_PK_DN_LSB = 0;
  localparam int ALC_RESTART_BIT = 5;
  localparam int ALC_FRZ_MSB = 4;
  localparam int ALC_FRZ_LSB = 2;
  localparam int ALC_START_MSB = 1;
  localparam int ALC_START_LSB = 0;

  // peak filter exponent offsets: attack 2^-(code+1), decay adds 2^-(code+2)
  localparam logic [3:0] ALC_ATTACK_OFS = 4'h1;
  localparam logic [4:0] ALC_DECAY_OFS = 5'h02;

  // freeze delay prescale: predecimation strobe divided by four
  localparam logic [1:0] ALC_PRESCALE_LAST = 2'h3;

  // gain-control start selections
  localparam logic [1:0] ALC_START_OFF = 2'h0;
  localparam logic [1:0] ALC_START_DIRECT = 2'h1;
  localparam logic [1:0] ALC_START_LEVEL = 2'h2;
  localparam logic [1:0] ALC_START_RECOG = 2'h3;

  // gain-control freeze selections
  localparam logic [2:0] ALC_FRZ_NEVER = 3'h0;
  localparam logic [2:0] ALC_FRZ_LEVEL = 3'h1;
  localparam logic [2:0] ALC_FRZ_RECOG = 3'h2;
  localparam logic [2:0] ALC_FRZ_SYNC = 3'h3;
  localparam logic [2:0] ALC_FRZ_MANUAL = 3'h4;

  // gain-control sequencer, gray along off-wait-run-delay-frozen
  typedef enum logic [2:0] {
    ALC_ST_OFF = 3'h0,
    ALC_ST_WAIT = 3'h1,
    ALC_ST_RUN = 3'h3,
    ALC_ST_DELAY = 3'h2,
    ALC_ST_FROZEN = 3'h6
  } alc_agc_st_t;

  // gain-control events from the baseband
  typedef struct packed {
    logic level_event;
    logic recog_event;
    logic symbol_sync;
    logic manual_freeze;
    logic channel_change;
    logic config_start;
    logic hold_exit;
    logic run_mode_slave;
    logic pll_hold_init;
  } alc_events_t;

  // host register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } alc_regreq_t;

  // whole state of the configuration block
  typedef struct packed {
    logic [3:0] g1_hi;
    logic [7:0] g2_lo;
    logic [3:0] g2_hi;
    logic [2:0] pk_up;
    logic [2:0] pk_dn;
    logic restart_en;
    logic [2:0] frz_sel;
    logic [1:0] start_sel;
    logic g1_hi_pend;
    logic g1_lo_pend;
    logic g2_lo_pend;
    logic g2_hi_pend;
    logic [11:0] gain1_act;
    logic [11:0] gain2_act;
    logic [7:0] rdata;
    alc_agc_st_t st;
    logic restart_p;
  } alc_state_t;

  // state of the freeze delay timer
  typedef struct packed {
    logic busy;
    logic [1:0] pre;
    logic [7:0] div;
    logic [7:0] cnt;
    logic done;
  } alc_tmr_t;

endpackage : alc_pkg

// ==== design/alc_delay_timer.sv ====
// freeze delay timer: prescaled predecimation strobe, ratio divider, 8-bit count
`timescale 1ns/1ns
module alc_delay_timer import alc_pkg::*; (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // control
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic strobe_in,
  input wire logic [7:0] ratio_in,
  input wire logic [7:0] delay_in,
  // result
  output logic done_out
);

  alc_tmr_t s_r;
  alc_tmr_t s_nxt;
  logic [7:0] last_div;

  // a ratio of zero would never tick, so it acts as one
  assign last_div = (ratio_in == 8'h00) ? 8'h00 : ratio_in - 8'h01;

  // count strobes / 4, then / ratio, then the programmed delay plus one ticks
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (abort_in || start_in) begin
      s_nxt.busy = start_in & ~abort_in;
      s_nxt.pre = 2'h0;
      s_nxt.div = 8'h00;
      s_nxt.cnt = 8'h00;
    end else if (s_r.busy && strobe_in) begin
      s_nxt.pre = s_r.pre + 2'h1;
      if (s_r.pre == ALC_PRESCALE_LAST) begin
        s_nxt.div = s_r.div + 8'h01;
        if (s_r.div >= last_div) begin
          s_nxt.div = 8'h00;
          if (s_r.cnt >= delay_in) begin
            s_nxt.done = 1'b1;
            s_nxt.busy = 1'b0;
          end else begin
            s_nxt.cnt = s_r.cnt + 8'h01;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign done_out = s_r.done;

  // completion only follows a predecimation strobe while armed
  chk_delay_on_strobe: assert property (@(posedge mclk_in) disable iff (reset_in)
    done_out |-> $past(strobe_in) && $past(s_r.busy))
    else $error("delay done without a strobe");

endmodule : alc_delay_timer

// ==== design/alc_loop_cfg.sv ====
// frequency loop gains, peak filter factors and gain-control start/freeze sequencer
// Operation
// - first gain is stored upper nibble over the external low byte
// - second gain is upper nibble over lower byte
// - attack code selects shift of code plus one, reset code four
// - decay code adds shift of code plus two on attack, reset two
// - start select: off, direct, on level event, on recognition event
// - freeze select: never, or delay after level, recognition or sync
// - freeze code four freezes on manual command; host avoids codes above
// - restart enable restarts on channel change, config start, slave hold exit
// - freeze delay counts predecimation strobe over four, times ratio
`timescale 1ns/1ns
module alc_loop_cfg import alc_pkg::*; (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // serial control port register access
  input wire alc_regreq_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  // first gain low byte, held in another register bank
  input wire logic [7:0] freq_gain1_lower_byte_in,
  input wire logic freq_gain1_lower_byte_wr_in,
  // baseband events and freeze delay setup
  input wire alc_events_t events_in,
  input wire logic predecim_strobe_in,
  input wire logic [7:0] freeze_delay_in,
  input wire logic [7:0] freeze_delay_ratio_in,
  // loop settings
  output logic [11:0] freq_gain1_out,
  output logic [11:0] freq_gain2_out,
  output logic [3:0] peak_attack_shift_out,
  output logic [4:0] peak_decay_shift_out,
  // gain-control status
  output logic agc_active_out,
  output logic agc_frozen_out,
  output logic agc_restart_out
);

  alc_state_t s_r;
  alc_state_t s_nxt;
  logic wr_g1h;
  logic wr_g2l;
  logic wr_g2h;
  logic wr_pk;
  logic wr_sf;
  logic restart_trig;
  logic start_ok;
  logic freeze_trig;
  logic tmr_start;
  logic tmr_abort;
  logic tmr_done;
  logic commit1;
  logic commit2;

  // write address decode for one register
  function automatic logic hit(input alc_regreq_t r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction : hit

  assign wr_g1h = hit(reg_req_in, ALC_ADDR_GAIN1_HI);
  assign wr_g2l = hit(reg_req_in, ALC_ADDR_GAIN2_LO);
  assign wr_g2h = hit(reg_req_in, ALC_ADDR_GAIN2_HI);
  assign wr_pk = hit(reg_req_in, ALC_ADDR_PEAK);
  assign wr_sf = hit(reg_req_in, ALC_ADDR_START_FREEZE);

  // restart sources, hold exit counts only as run mode slave with pll hold init
  assign restart_trig = s_r.restart_en && (events_in.channel_change || events_in.config_start ||
    (events_in.run_mode_slave && events_in.pll_hold_init && events_in.hold_exit));

  // start condition per start selection
  always_comb begin
    unique case (s_r.start_sel)
      ALC_START_OFF: start_ok = 1'b0;
      ALC_START_DIRECT: start_ok = 1'b1;
      ALC_START_LEVEL: start_ok = events_in.level_event;
      ALC_START_RECOG: start_ok = events_in.recog_event;
    endcase
  end

  // delayed freeze triggers; manual and unused codes never arm the timer
  always_comb begin
    case (s_r.frz_sel)
      ALC_FRZ_LEVEL: freeze_trig = events_in.level_event;
      ALC_FRZ_RECOG: freeze_trig = events_in.recog_event;
      ALC_FRZ_SYNC: freeze_trig = events_in.symbol_sync;
      default: freeze_trig = 1'b0;
    endcase
  end

  assign commit1 = (s_r.g1_hi_pend || wr_g1h) && (s_r.g1_lo_pend || freq_gain1_lower_byte_wr_in);
  assign commit2 = (s_r.g2_hi_pend || wr_g2h) && (s_r.g2_lo_pend || wr_g2l);

  // register file, gain commit and gain-control sequencer
  always_comb begin
    s_nxt = s_r;
    s_nxt.restart_p = 1'b0;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    // only defined bits are stored, so unused bits stay zero
    if (wr_g1h) s_nxt.g1_hi = reg_req_in.wdata[ALC_NIB_MSB:0];
    if (wr_g2l) s_nxt.g2_lo = reg_req_in.wdata;
    if (wr_g2h) s_nxt.g2_hi = reg_req_in.wdata[ALC_NIB_MSB:0];
    if (wr_pk) begin
      s_nxt.pk_up = reg_req_in.wdata[ALC_PK_UP_MSB:ALC_PK_UP_LSB];
      s_nxt.pk_dn = reg_req_in.wdata[ALC_PK_DN_MSB:ALC_PK_DN_LSB];
    end
    if (wr_sf) begin
      s_nxt.restart_en = reg_req_in.wdata[ALC_RESTART_BIT];
      s_nxt.frz_sel = reg_req_in.wdata[ALC_FRZ_MSB:ALC_FRZ_LSB];
      s_nxt.start_sel = reg_req_in.wdata[ALC_START_MSB:ALC_START_LSB];
    end
    // half-written gains wait until the other half arrives
    s_nxt.g1_hi_pend = s_r.g1_hi_pend | wr_g1h;
    s_nxt.g1_lo_pend = s_r.g1_lo_pend | freq_gain1_lower_byte_wr_in;
    if (commit1) begin
      s_nxt.gain1_act = {s_nxt.g1_hi, freq_gain1_lower_byte_in};
      s_nxt.g1_hi_pend = 1'b0;
      s_nxt.g1_lo_pend = 1'b0;
    end
    s_nxt.g2_hi_pend = s_r.g2_hi_pend | wr_g2h;
    s_nxt.g2_lo_pend = s_r.g2_lo_pend | wr_g2l;
    if (commit2) begin
      s_nxt.gain2_act = {s_nxt.g2_hi, s_nxt.g2_lo};
      s_nxt.g2_hi_pend = 1'b0;
      s_nxt.g2_lo_pend = 1'b0;
    end
    // readback one cycle after the strobe, unmapped reads zero
    if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        ALC_ADDR_GAIN1_HI: s_nxt.rdata = {4'h0, s_r.g1_hi};
        ALC_ADDR_GAIN2_LO: s_nxt.rdata = s_r.g2_lo;
        ALC_ADDR_GAIN2_HI: s_nxt.rdata = {4'h0, s_r.g2_hi};
        ALC_ADDR_PEAK: s_nxt.rdata = {1'b0, s_r.pk_up, 1'b0, s_r.pk_dn};
        ALC_ADDR_START_FREEZE: s_nxt.rdata = {2'h0, s_r.restart_en, s_r.frz_sel, s_r.start_sel};
        default: s_nxt.rdata = 8'h00;
      endcase
    end
    // sequencer: start off wins, then restart, then normal progress
    if (s_r.start_sel == ALC_START_OFF) begin
      s_nxt.st = ALC_ST_OFF;
      tmr_abort = 1'b1;
    end else if (restart_trig) begin
      s_nxt.st = ALC_ST_WAIT;
      s_nxt.restart_p = 1'b1;
      tmr_abort = 1'b1;
    end else begin
      unique case (s_r.st)
        ALC_ST_OFF: s_nxt.st = ALC_ST_WAIT;
        ALC_ST_WAIT: if (start_ok) s_nxt.st = ALC_ST_RUN;
        ALC_ST_RUN: begin
          if (s_r.frz_sel == ALC_FRZ_MANUAL && events_in.manual_freeze) begin
            s_nxt.st = ALC_ST_FROZEN;
          end else if (freeze_trig) begin
            s_nxt.st = ALC_ST_DELAY;
            tmr_start = 1'b1;
          end
        end
        ALC_ST_DELAY: if (tmr_done) s_nxt.st = ALC_ST_FROZEN;
        ALC_ST_FROZEN: s_nxt.st = ALC_ST_FROZEN;
      endcase
    end
  end

  // reset values come from the documented register defaults
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      s_r <= '0;
      s_r.pk_up <= ALC_RST_PEAK[ALC_PK_UP_MSB:ALC_PK_UP_LSB];
      s_r.pk_dn <= ALC_RST_PEAK[ALC_PK_DN_MSB:ALC_PK_DN_LSB];
      s_r.g1_hi <= ALC_RST_GAIN1_HI[ALC_NIB_MSB:0];
      s_r.g2_lo <= ALC_RST_GAIN2_LO;
      s_r.g2_hi <= ALC_RST_GAIN2_HI[ALC_NIB_MSB:0];
      s_r.restart_en <= ALC_RST_START_FREEZE[ALC_RESTART_BIT];
      s_r.st <= ALC_ST_OFF;
    end else begin
      s_r <= s_nxt;
    end
  end

  // freeze delay timer shared by all delayed freeze selections
  alc_delay_timer u_delay (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .start_in(tmr_start),
    .abort_in(tmr_abort),
    .strobe_in(predecim_strobe_in),
    .ratio_in(freeze_delay_ratio_in),
    .delay_in(freeze_delay_in),
    .done_out(tmr_done)
  );

  // outputs; exponents are derived straight from stored codes
  assign reg_rdata_out = s_r.rdata;
  assign freq_gain1_out = s_r.gain1_act;
  assign freq_gain2_out = s_r.gain2_act;
  assign peak_attack_shift_out = {1'b0, s_r.pk_up} + ALC_ATTACK_OFS;
  assign peak_decay_shift_out = {1'b0, peak_attack_shift_out} + {2'h0, s_r.pk_dn} + ALC_DECAY_OFS;
  assign agc_active_out = (s_r.st == ALC_ST_RUN) || (s_r.st == ALC_ST_DELAY);
  assign agc_frozen_out = (s_r.st == ALC_ST_FROZEN);
  assign agc_restart_out = s_r.restart_p;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  sequence manual_cmd_s;
    s_r.st == ALC_ST_RUN && s_r.frz_sel == ALC_FRZ_MANUAL && events_in.manual_freeze;
  endsequence
  sequence steady_s;
    s_r.start_sel != ALC_START_OFF && !restart_trig;
  endsequence

  chk_gain1_concat: assert property (freq_gain1_lower_byte_wr_in && s_r.g1_hi_pend && !wr_g1h |=>
    freq_gain1_out == {$past(s_r.g1_hi), $past(freq_gain1_lower_byte_in)})
    else $error("first gain not formed from nibble and low byte");
  chk_gain2_concat: assert property (wr_g2l && s_r.g2_hi_pend && !wr_g2h |=>
    freq_gain2_out == {s_r.g2_hi, $past(reg_req_in.wdata)})
    else $error("second gain not formed from nibble and byte");
  chk_attack_code: assert property (wr_pk |=>
    peak_attack_shift_out == {1'b0, $past(reg_req_in.wdata[6:4])} + 4'h1)
    else $error("attack shift does not follow code");
  chk_decay_code: assert property (wr_pk |=>
    peak_decay_shift_out == {2'h0, $past(reg_req_in.wdata[6:4])} + {2'h0, $past(reg_req_in.wdata[2:0])} + 5'h03)
    else $error("decay shift does not follow codes");
  chk_start_direct: assert property (s_r.st == ALC_ST_WAIT && s_r.start_sel == ALC_START_DIRECT
    && !restart_trig |=> agc_active_out)
    else $error("direct start did not activate gain control");
  chk_never_freeze: assert property (s_r.st == ALC_ST_RUN && s_r.frz_sel == ALC_FRZ_NEVER and steady_s
    |=> s_r.st == ALC_ST_RUN)
    else $error("gain control left run with freeze never");
  chk_manual_freeze: assert property (manual_cmd_s and steady_s |=> agc_frozen_out)
    else $error("manual freeze command not obeyed");
  chk_restart_pulse: assert property (restart_trig && s_r.start_sel != ALC_START_OFF
    |=> agc_restart_out && s_r.st == ALC_ST_WAIT ##1 !agc_restart_out || $past(restart_trig))
    else $error("restart not taken");
  chk_unused_zero: assert property (reg_req_in.rd && reg_req_in.addr == ALC_ADDR_PEAK
    |=> reg_rdata_out[7] == 1'b0 && reg_rdata_out[3] == 1'b0)
    else $error("unused peak bits read nonzero");
  chk_gain_hold: assert property (!commit2 |=> $stable(freq_gain2_out))
    else $error("second gain changed on a half write");

endmodule : alc_loop_cfg

// ==== bench/alc_host_model.sv ====
// host model: register writes and reads on the serial control port
`timescale 1ns/1ns
module alc_host_model import alc_pkg::*; (
  // clock and read data
  input wire logic mclk_in,
  input wire logic [7:0] rdata_in,
  // register request
  output alc_regreq_t req_out
);
  initial req_out = '0;
  // write strobe for one cycle; released lines show the inverse, never stale values
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    // never send the unused freeze codes
    if (a == ALC_ADDR_START_FREEZE && v[4:2] > ALC_FRZ_MANUAL) v[4:2] = ALC_FRZ_NEVER;
    @(negedge mclk_in);
    req_out = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge mclk_in);
    req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
  endtask : wr_reg
  // read strobe for one cycle; data is registered, taken one cycle on
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_in);
    req_out = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge mclk_in);
    req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    d = rdata_in;
  endtask : rd_reg
endmodule : alc_host_model

// ==== bench/tb_alc_loop_cfg.sv ====
// self-checking bench for the loop configuration block
`timescale 1ns/1ns
module tb_alc_loop_cfg import alc_pkg::*; ();
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  alc_regreq_t req;
  alc_events_t ev = '0;
  logic [7:0] rdata, d, w, a;
  logic [7:0] lo_byte = 8'h00;
  logic lo_wr = 1'b0;
  logic [7:0] dly = 8'h02;
  logic [7:0] ratio = 8'h02;
  int n;
  logic [11:0] g1, g2;
  logic [3:0] atk;
  logic [4:0] dcy;
  logic act, frz, rst_p;
  int errors = 0;
  int cmp_count = 0;
  int seed = 32482;

  // 100 ns clock
  always #50 mclk_in = ~mclk_in;

  alc_host_model u_host (.mclk_in(mclk_in), .rdata_in(rdata), .req_out(req));
  // strobe every cycle keeps the freeze delay short and exact; delay and ratio vary per test
  alc_loop_cfg u_dut (.mclk_in(mclk_in), .reset_in(reset_in), .reg_req_in(req), .reg_rdata_out(rdata),
    .freq_gain1_lower_byte_in(lo_byte), .freq_gain1_lower_byte_wr_in(lo_wr), .events_in(ev),
    .predecim_strobe_in(1'b1), .freeze_delay_in(dly), .freeze_delay_ratio_in(ratio),
    .freq_gain1_out(g1), .freq_gain2_out(g2), .peak_attack_shift_out(atk), .peak_decay_shift_out(dcy),
    .agc_active_out(act), .agc_frozen_out(frz), .agc_restart_out(rst_p));

  // expected readback: writable bits only, unmapped reads zero
  function automatic logic [7:0] exp_rd(input logic [7:0] ad, input logic [7:0] v);
    logic [7:0] m;
    case (ad)
      8'h2e, 8'h30: m = 8'h0f;
      8'h2f: m = 8'hff;
      8'h31: m = 8'h77;
      8'h32: m = 8'h3f;
      default: m = 8'h00;
    endcase
    if (ad == 8'h32 && v[4:2] > 3'h4) v[4:2] = 3'h0;
    return v & m;
  endfunction : exp_rd

  // strobes until freeze: four per base tick, ratio zero acts as one
  function automatic int exp_strobes(input logic [7:0] dl, input logic [7:0] rt);
    return (int'(dl) + 1) * 4 * ((rt == 8'h00) ? 1 : int'(rt));
  endfunction : exp_strobes

  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] s);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic pulse(input int k);
    @(negedge mclk_in);
    ev[k] = 1'b1;
    @(negedge mclk_in);
    ev[k] = 1'b0;
  endtask : pulse

  // back to off first so every selection starts from a clean sequencer
  task automatic set_cfg(input logic [7:0] v);
    u_host.wr_reg(8'h32, 8'h00);
    u_host.wr_reg(8'h32, v);
    repeat (4) @(negedge mclk_in);
  endtask : set_cfg

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  // watchdog sized well above the few hundred cycles of the tests
  initial begin
    repeat (8000) @(posedge mclk_in);
    errors++;
    stop_test;
  end

  initial begin
    repeat (13) @(negedge mclk_in);
    reset_in = 1'b0;
    for (int i = 0; i < 6; i++) begin
      a = 8'h2e + 8'(i);
      u_host.rd_reg(a, d);
      chk("reset read", 12'(exp_rd(a, (a == 8'h31) ? 8'h42 : 8'h00)), 12'(d));
    end
    chk("attack shift", 12'h005, 12'(atk));
    chk("decay shift", 12'h009, 12'(dcy));
    $display("test reset done");
    // halves arrive apart; upper bits of the high write are unused
    u_host.wr_reg(8'h30, 8'hf5);
    repeat (2) @(negedge mclk_in);
    chk("gain2 half", 12'h000, g2);
    u_host.wr_reg(8'h2f, 8'hab);
    @(negedge mclk_in);
    chk("gain2", 12'h5ab, g2);
    u_host.wr_reg(8'h2e, 8'h13);
    repeat (2) @(negedge mclk_in);
    chk("gain1 half", 12'h000, g1);
    @(negedge mclk_in);
    lo_byte = 8'h9c;
    lo_wr = 1'b1;
    @(negedge mclk_in);
    lo_wr = 1'b0;
    lo_byte = 8'h63;
    @(negedge mclk_in);
    chk("gain1", 12'h39c, g1);
    $display("test gain pairing done");
    // random writes over all offsets plus one unmapped
    for (int i = 0; i < 40; i++) begin
      a = 8'h2e + 8'($unsigned($random(seed)) % 6);
      w = 8'($random(seed));
      u_host.wr_reg(a, w);
      u_host.rd_reg(a, d);
      chk("readback", 12'(exp_rd(a, w)), 12'(d));
      if (a == 8'h31) begin
        chk("attack", 12'(w[6:4]) + 12'h001, 12'(atk));
        chk("decay", 12'(w[6:4]) + 12'(w[2:0]) + 12'h003, 12'(dcy));
      end
    end
    $display("test random registers done");
    set_cfg(8'h00);
    chk("off", 12'h000, 12'(act));
    set_cfg(8'h01);
    chk("direct", 12'h001, 12'(act));
    for (int s = 2; s < 4; s++) begin
      set_cfg(8'(s));
      chk("wait start", 12'h000, 12'(act));
      pulse(10 - s);
      repeat (2) @(negedge mclk_in);
      chk("started", 12'h001, 12'(act));
    end
    $display("test start select done");
    // random delay and ratio, ratio zero forced once; frozen exactly one cycle after the last strobe
    for (int f = 1; f < 4; f++) begin
      dly = 8'($unsigned($random(seed)) % 4);
      ratio = (f == 2) ? 8'h00 : 8'($unsigned($random(seed)) % 3);
      n = exp_strobes(dly, ratio);
      set_cfg(8'(f << 2) | 8'h01);
      pulse(9 - f);
      repeat (n) @(negedge mclk_in);
      chk("delay running", 12'h000, 12'(frz));
      @(negedge mclk_in);
      chk("frozen", 12'h001, 12'(frz));
    end
    set_cfg(8'h01);
    pulse(8);
    pulse(7);
    pulse(6);
    repeat (30) @(negedge mclk_in);
    chk("never freeze", 12'h000, 12'(frz));
    $display("test freeze select done");
    ev[1] = 1'b1;
    ev[0] = 1'b1;
    set_cfg(8'h31);
    for (int t = 0; t < 3; t++) begin
      pulse(5);
      @(negedge mclk_in);
      chk("manual freeze", 12'h001, 12'(frz));
      pulse(4 - t);
      chk("restart", 12'h001, 12'(rst_p));
      repeat (4) @(negedge mclk_in);
      chk("rerun", 12'h001, 12'({frz, act}));
    end
    set_cfg(8'h11);
    pulse(5);
    pulse(4);
    chk("no restart", 12'h000, 12'(rst_p));
    chk("stay frozen", 12'h001, 12'(frz));
    $display("test restart done");
    stop_test;
  end
endmodule : tb_alc_loop_cfg
